// ===== src/vpq_pkg.sv
// Constants shared by the VLAN priority to queue mapping block.
package vpq_pkg;

	// ************************************************************
	// Register offsets on the management port.
	// ************************************************************
	localparam logic [7:0] VPQ_LOW_MAP_ADDR  = 8'h80;
	localparam logic [7:0] VPQ_HIGH_MAP_ADDR = 8'h81;
	localparam logic [7:0] VPQ_FOLD_ADDR     = 8'h82;

	// ************************************************************
	// Reset values.
	// ************************************************************
	// Priority codes 3,2 map to 1 and 1,0 map to 0.
	localparam logic [7:0] VPQ_LOW_MAP_RESET  = 8'h50;
	// Priority codes 7,6 map to 3 and 5,4 map to 2.
	localparam logic [7:0] VPQ_HIGH_MAP_RESET = 8'hFA;
	localparam logic [1:0] VPQ_FOLD_SEL_RESET = 2'h2;
	// Low bits of the fold register are read-only and fixed.
	localparam logic [5:0] VPQ_FOLD_RSV_VALUE = 6'h04;

	// ************************************************************
	// Field layout.
	// ************************************************************
	localparam int VPQ_FIELD_WIDTH   = 2;
	localparam int VPQ_FIELDS_PER_REG = 4;
	localparam int VPQ_FOLD_SEL_LSB  = 6;
	localparam int VPQ_FOLD_SEL_MSB  = 7;
	localparam int VPQ_TCI_PCP_LSB   = 13;
	localparam int VPQ_TCI_PCP_MSB   = 15;

	// ************************************************************
	// Queue priority results.
	// ************************************************************
	localparam logic [1:0] VPQ_RESULT_LOWEST  = 2'h0;
	localparam logic [1:0] VPQ_RESULT_ONE     = 2'h1;
	localparam logic [1:0] VPQ_RESULT_TWO     = 2'h2;
	localparam logic [1:0] VPQ_RESULT_HIGHEST = 2'h3;

	typedef enum logic {
		VPQ_SRC_VLAN,
		VPQ_SRC_TOS
	} vpq_source_type;

endpackage

// ===== src/vpq_two_queue_fold.sv
// Folds a 2-bit queue priority result into a low or high queue.
`timescale 1ns/1ns
module vpq_two_queue_fold
	import vpq_pkg::*;
(
	input  wire logic [1:0] i_result,
	input  wire logic [1:0] i_fold_select,
	output logic            o_high_queue
);

	// ************************************************************
	// Fold decode.
	// ************************************************************
	// Select 01 is unsupported but still decodes bit by bit, so a
	// misprogrammed part stays deterministic rather than undefined.
	always_comb begin
		o_high_queue = 1'b0;
		unique case (i_result)
			VPQ_RESULT_LOWEST: begin
				o_high_queue = 1'b0;
			end
			VPQ_RESULT_ONE: begin
				o_high_queue = i_fold_select[0];
			end
			VPQ_RESULT_TWO: begin
				o_high_queue = i_fold_select[1];
			end
			VPQ_RESULT_HIGHEST: begin
				o_high_queue = 1'b1;
			end
		endcase
	end

endmodule

// ===== src/vpq_vlan_priority_queue_map.sv
// VLAN priority to egress queue mapping registers and lookup.
`timescale 1ns/1ns

module vpq_vlan_priority_queue_map
	import vpq_pkg::*;
#(
	parameter int PCP_WIDTH  = 3,
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 8
)
(
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_b,
	input  wire logic [ADDR_WIDTH-1:0] i_reg_addr,
	input  wire logic                  i_reg_write,
	input  wire logic                  i_reg_read,
	input  wire logic [DATA_WIDTH-1:0] i_reg_wdata,
	input  wire logic                  i_frame_valid,
	input  wire logic                  i_frame_tagged,
	input  wire logic [15:0]           i_tag_control,
	input  wire logic                  i_use_tos_result,
	input  wire logic [1:0]            i_tos_result,
	input  wire logic [1:0]            i_port_default_result,
	input  wire logic                  i_two_queue_mode,
	output logic [DATA_WIDTH-1:0]      o_reg_rdata,
	output logic                       o_reg_rdata_valid,
	output logic                       o_result_valid,
	output logic [1:0]                 o_queue_number,
	output logic                       o_two_queue_high
);

	// ************************************************************
	// Elaboration checks.
	// ************************************************************
	// The map holds exactly eight 2-bit fields in two byte registers.
	generate
		if (PCP_WIDTH != 3) begin : g_bad_pcp
			$error("PCP_WIDTH must be 3");
		end
		if (DATA_WIDTH != 8) begin : g_bad_data
			$error("DATA_WIDTH must be 8");
		end
		if (ADDR_WIDTH != 8) begin : g_bad_addr
			$error("ADDR_WIDTH must be 8");
		end
	endgenerate

	// ************************************************************
	// Register state.
	// ************************************************************
	logic [DATA_WIDTH-1:0] low_map_q;
	logic [DATA_WIDTH-1:0] low_map_d;
	logic [DATA_WIDTH-1:0] high_map_q;
	logic [DATA_WIDTH-1:0] high_map_d;
	logic [1:0]            fold_select_q;
	logic [1:0]            fold_select_d;
	logic [DATA_WIDTH-1:0] rdata_q;
	logic [DATA_WIDTH-1:0] rdata_d;
	logic                  rdata_valid_q;
	logic                  rdata_valid_d;

	logic                  hit_low;
	logic                  hit_high;
	logic                  hit_fold;

	assign hit_low  = (i_reg_addr == VPQ_LOW_MAP_ADDR);
	assign hit_high = (i_reg_addr == VPQ_HIGH_MAP_ADDR);
	assign hit_fold = (i_reg_addr == VPQ_FOLD_ADDR);

	// ************************************************************
	// Register write and read decode.
	// ************************************************************
	// The select field takes any written value; keeping 01 out is
	// left to software, and the fold still decodes it bit by bit.
	always_comb begin
		low_map_d     = low_map_q;
		high_map_d    = high_map_q;
		fold_select_d = fold_select_q;
		rdata_d       = rdata_q;
		rdata_valid_d = 1'b0;
		if (i_reg_write) begin
			if (hit_low) begin
				low_map_d = i_reg_wdata;
			end
			if (hit_high) begin
				high_map_d = i_reg_wdata;
			end
			if (hit_fold) begin
				fold_select_d =
					i_reg_wdata[VPQ_FOLD_SEL_MSB:VPQ_FOLD_SEL_LSB];
			end
		end
		if (i_reg_read) begin
			rdata_valid_d = 1'b1;
			if (hit_low) begin
				rdata_d = low_map_q;
			end else if (hit_high) begin
				rdata_d = high_map_q;
			end else if (hit_fold) begin
				rdata_d = {fold_select_q, VPQ_FOLD_RSV_VALUE};
			end else begin
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_map_q     <= VPQ_LOW_MAP_RESET;
			high_map_q    <= VPQ_HIGH_MAP_RESET;
			fold_select_q <= VPQ_FOLD_SEL_RESET;
			rdata_q       <= '0;
			rdata_valid_q <= 1'b0;
		end else begin
			low_map_q     <= low_map_d;
			high_map_q    <= high_map_d;
			fold_select_q <= fold_select_d;
			rdata_q       <= rdata_d;
			rdata_valid_q <= rdata_valid_d;
		end
	end

	// ************************************************************
	// Mapping field table.
	// ************************************************************
	localparam int NUM_FIELDS = 2 * VPQ_FIELDS_PER_REG;

	logic [1:0] map_field [NUM_FIELDS];

	// Entries 0-3 come from the low map, 4-7 from the high map.
	generate
		for (genvar g = 0; g < VPQ_FIELDS_PER_REG; g++) begin : g_field
			assign map_field[g] =
				low_map_q[g*VPQ_FIELD_WIDTH +: VPQ_FIELD_WIDTH];
			assign map_field[g+VPQ_FIELDS_PER_REG] =
				high_map_q[g*VPQ_FIELD_WIDTH +: VPQ_FIELD_WIDTH];
		end
	endgenerate

	// ************************************************************
	// Frame lookup.
	// ************************************************************
	logic [PCP_WIDTH-1:0] frame_pcp;
	logic [1:0]           result_mux;
	logic                 fold_high;

	assign frame_pcp =
		i_tag_control[VPQ_TCI_PCP_MSB:VPQ_TCI_PCP_LSB];

	// An untagged frame without a TOS result has no priority code,
	// so it falls back to the port's default queue priority.
	always_comb begin
		result_mux = i_port_default_result;
		if (i_use_tos_result) begin
			result_mux = i_tos_result;
		end else if (i_frame_tagged) begin
			result_mux = map_field[frame_pcp];
		end
	end

	vpq_two_queue_fold u_fold (
		.i_result      (result_mux),
		.i_fold_select (fold_select_q),
		.o_high_queue  (fold_high)
	);

	// ************************************************************
	// Result outputs.
	// ************************************************************
	logic       result_valid_q;
	logic       result_valid_d;
	logic [1:0] queue_number_q;
	logic [1:0] queue_number_d;
	logic       two_queue_high_q;
	logic       two_queue_high_d;

	// In four-queue operation the result is the queue number itself,
	// 3 served first. In two-queue mode only queues 0 and 3 are used,
	// which keeps the scheduler's strict order unchanged.
	always_comb begin
		result_valid_d   = i_frame_valid;
		queue_number_d   = queue_number_q;
		two_queue_high_d = two_queue_high_q;
		if (i_frame_valid) begin
			two_queue_high_d = fold_high;
			if (i_two_queue_mode) begin
				queue_number_d = fold_high ? VPQ_RESULT_HIGHEST
				                           : VPQ_RESULT_LOWEST;
			end else begin
				queue_number_d = result_mux;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			result_valid_q   <= 1'b0;
			queue_number_q   <= VPQ_RESULT_LOWEST;
			two_queue_high_q <= 1'b0;
		end else begin
			result_valid_q   <= result_valid_d;
			queue_number_q   <= queue_number_d;
			two_queue_high_q <= two_queue_high_d;
		end
	end

	assign o_reg_rdata       = rdata_q;
	assign o_reg_rdata_valid = rdata_valid_q;
	assign o_result_valid    = result_valid_q;
	assign o_queue_number    = queue_number_q;
	assign o_two_queue_high  = two_queue_high_q;

endmodule

// ===== bench/vpq_map_properties.sv
// Port-level checks for the VLAN priority queue mapping block.
`timescale 1ns/1ns
module vpq_map_properties #(
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 8
)
(
	input wire logic                  i_clock,
	input wire logic                  i_rst_b,
	input wire logic [ADDR_WIDTH-1:0] i_reg_addr,
	input wire logic                  i_reg_read,
	input wire logic                  i_frame_valid,
	input wire logic                  i_use_tos_result,
	input wire logic [1:0]            i_tos_result,
	input wire logic                  i_two_queue_mode,
	input wire logic [DATA_WIDTH-1:0] o_reg_rdata,
	input wire logic                  o_reg_rdata_valid,
	input wire logic                  o_result_valid,
	input wire logic [1:0]            o_queue_number,
	input wire logic                  o_two_queue_high
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	sequence s_tos_frame;
		i_frame_valid && i_use_tos_result;
	endsequence
	a_read_answer: assert property (i_reg_read |=> o_reg_rdata_valid)
		else $error("read got no answer");
	a_lookup_answer: assert property (i_frame_valid |=> o_result_valid)
		else $error("lookup got no answer");
	a_zero_low: assert property (
		s_tos_frame ##0 i_tos_result == 2'h0 |=> !o_two_queue_high)
		else $error("result 0 not low");
	a_three_high: assert property (
		s_tos_frame ##0 i_tos_result == 2'h3 |=> o_two_queue_high)
		else $error("result 3 not high");
	a_four_queue: assert property (s_tos_frame ##0 !i_two_queue_mode
		|=> o_queue_number == $past(i_tos_result))
		else $error("queue not equal to result");
	a_two_queue_ends: assert property (o_result_valid &&
		$past(i_two_queue_mode) |-> o_queue_number == {2{o_two_queue_high}})
		else $error("two-queue number wrong");
	a_unmapped_zero: assert property (i_reg_read &&
		(i_reg_addr < 8'h80 || i_reg_addr > 8'h82) |=> o_reg_rdata == '0)
		else $error("unmapped read not zero");
	a_result_holds: assert property (!o_result_valid |->
		$stable(o_queue_number) && $stable(o_two_queue_high))
		else $error("result moved without valid");
	a_rdata_holds: assert property (!o_reg_rdata_valid |-> $stable(o_reg_rdata))
		else $error("read data moved without valid");
endmodule

// ===== bench/tb_vpq_vlan_priority_queue_map.sv
// Self-checking bench for the VLAN priority queue mapping block.
`timescale 1ns/1ns
module tb_vpq_vlan_priority_queue_map;
	logic        i_clock, i_rst_b, i_reg_write, i_reg_read, i_frame_valid;
	logic        i_frame_tagged, i_use_tos_result, i_two_queue_mode;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, lo, hi, fold;
	logic [15:0] i_tag_control;
	logic [1:0]  i_tos_result, i_port_default_result, o_queue_number;
	logic        o_reg_rdata_valid, o_result_valid, o_two_queue_high;
	logic [31:0] v;
	int          mismatches, check_count;
	vpq_vlan_priority_queue_map i_dut (.i_clock, .i_rst_b, .i_reg_addr,
		.i_reg_write, .i_reg_read, .i_reg_wdata, .i_frame_valid,
		.i_frame_tagged, .i_tag_control, .i_use_tos_result, .i_tos_result,
		.i_port_default_result, .i_two_queue_mode, .o_reg_rdata,
		.o_reg_rdata_valid, .o_result_valid, .o_queue_number,
		.o_two_queue_high);
	// ************************************************************
	// Shared tasks.
	// ************************************************************
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_write <= 1'b1;
		@(posedge i_clock);
		i_reg_write <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_read <= 1'b1;
		@(posedge i_clock);
		i_reg_read <= 1'b0;
		#1 chk("rdata_valid", 8'h01, {7'h00, o_reg_rdata_valid});
		chk("rdata", e, o_reg_rdata);
	endtask
	// Returns the fold bit above the 2-bit queue priority result.
	function automatic logic [2:0] expect_q(logic t, logic [2:0] p,
		logic u, logic [1:0] r, logic [1:0] d);
		logic [1:0] e;
		e = u ? r : !t ? d : p[2] ? hi[2*p[1:0]+:2] : lo[2*p[1:0]+:2];
		return {e == 2'h3 || (e == 2'h1 && fold[6]) ||
			(e == 2'h2 && fold[7]), e};
	endfunction
	task automatic look(logic t, logic [2:0] p, logic u, logic [1:0] r,
		logic m);
		logic [1:0] d;
		logic [2:0] x;
		d = 2'(p + 3'h5);
		x = expect_q(t, p, u, r, d);
		@(posedge i_clock);
		i_frame_valid <= 1'b1;
		i_frame_tagged <= t;
		i_tag_control <= {p, 13'h1abc};
		i_use_tos_result <= u;
		i_tos_result <= r;
		i_port_default_result <= d;
		i_two_queue_mode <= m;
		@(posedge i_clock);
		i_frame_valid <= 1'b0;
		#1 chk("result_valid", 8'h01, {7'h00, o_result_valid});
		chk("queue", {6'h00, m ? {2{x[2]}} : x[1:0]}, {6'h00, o_queue_number});
		chk("fold_high", {7'h00, x[2]}, {7'h00, o_two_queue_high});
	endtask
	task automatic rst_chk;
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_b <= 1'b1;
		#1 chk("queue_reset", 8'h00, {6'h00, o_queue_number});
		chk("fold_high_reset", 8'h00, {7'h00, o_two_queue_high});
		chk("result_valid_reset", 8'h00, {7'h00, o_result_valid});
		chk("rdata_valid_reset", 8'h00, {7'h00, o_reg_rdata_valid});
		lo = 8'h50;
		hi = 8'hfa;
		fold = 8'h84;
		rd(8'h80, lo);
		rd(8'h81, hi);
		rd(8'h82, fold);
		$display("reset values test done");
	endtask
	// ************************************************************
	// Clock, watchdog and test sequence.
	// ************************************************************
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	initial begin
		#3000000;
		mismatches++;
		end_sim;
	end
	initial begin
		{i_reg_write, i_reg_read, i_frame_valid, i_frame_tagged} = '0;
		{i_use_tos_result, i_two_queue_mode, i_reg_addr, i_reg_wdata} = '0;
		{i_tag_control, i_tos_result, i_port_default_result} = '0;
		void'($urandom(32'h36c5_67ff));
		rst_chk();
		for (int p = 0; p < 8; p++) begin
			look(1'b1, p[2:0], 1'b0, 2'h0, 1'b0);
			look(1'b1, p[2:0], 1'b0, 2'h0, 1'b1);
		end
		$display("reset map lookup test done");
		for (int s = 0; s < 4; s++) begin
			if (s == 1) continue;
			fold = {s[1:0], 6'h04};
			wr(8'h82, {s[1:0], 6'h3b});
			rd(8'h82, fold);
			for (int r = 0; r < 4; r++) begin
				look(1'b0, 3'h0, 1'b1, r[1:0], 1'b1);
				look(1'b0, 3'h0, 1'b1, r[1:0], 1'b0);
			end
		end
		wr(8'h83, 8'hff);
		rd(8'h83, 8'h00);
		rd(8'h7f, 8'h00);
		$display("fold and unmapped test done");
		for (int i = 0; i < 60; i++) begin
			v = $urandom;
			lo = v[31:24];
			hi = v[23:16];
			wr(8'h80, lo);
			wr(8'h81, hi);
			look(v[0], v[3:1], v[4] & v[5], v[7:6], v[8]);
			look(1'b1, v[11:9], 1'b0, 2'h0, v[12]);
		end
		$display("random map test done");
		rst_chk();
		end_sim;
	end
endmodule
bind vpq_vlan_priority_queue_map vpq_map_properties #(
	.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) i_props (.i_clock,
	.i_rst_b, .i_reg_addr, .i_reg_read, .i_frame_valid, .i_use_tos_result,
	.i_tos_result, .i_two_queue_mode, .o_reg_rdata, .o_reg_rdata_valid,
	.o_result_valid, .o_queue_number, .o_two_queue_high);
